/* rtl/rtw_capture_watchdog.sv */
// Capture source select, capture latches, digital watchdog and their registers
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

module rtw_capture_watchdog
  import rtw_pkg::*;
(
  input wire logic clk, // System clock, 25 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire rtw_bus_req_s bus_req, // Register port request
  output logic [31:0] rdata, // Read data, cycle after read strobe
  input wire logic [RTW_NUM_EVENTS-1:0] dma_event, // Serial port DMA event pulses
  input wire rtw_count_s [RTW_NUM_CAPTURES-1:0] counter_in, // Live counter values
  input wire logic analog_wd_flag, // Analog watchdog state
  output logic [RTW_NUM_CAPTURES-1:0] capture_pulse, // Capture happened
  output logic wd_reset_req, // Processor reset request
  output logic irq // Level interrupt
);

  // Decoded strobes
  logic wr_cfg; // Write to capture source config
  logic wr_ctrl; // Write to watchdog control
  logic wr_prld; // Write to preload
  logic wr_key; // Write to key register
  logic wr_isr; // Write to interrupt status
  logic wr_imask; // Write to interrupt mask

  // Register state
  logic [RTW_SEL_W-1:0] sel_q [RTW_NUM_CAPTURES]; // Capture source selects
  rtw_count_s cap_q [RTW_NUM_CAPTURES]; // Captured counter values
  logic [RTW_NUM_CAPTURES-1:0] cap_hit; // Selected event this cycle
  logic [RTW_NUM_CAPTURES-1:0] capture_pulse_q; // Registered capture pulse
  logic wd_en_q; // Watchdog running
  logic [31:0] preload_q; // Expiry preload
  logic [31:0] cnt_q; // Down-counter
  logic expired_q; // Watchdog ran out
  logic key_err_q; // Wrong key seen
  logic wd_reset_q; // Reset request flop
  rtw_key_state_e key_q; // Key sequence state
  logic service; // Correct second key written
  logic key_bad; // Key write out of sequence
  logic expire_now; // Counter at zero, unserviced
  logic [RTW_IRQ_W-1:0] isr_q; // Sticky interrupt status
  logic [RTW_IRQ_W-1:0] imask_q; // Interrupt mask
  logic [RTW_IRQ_W-1:0] irq_set; // Events for status
  logic irq_q; // Interrupt output flop
  logic [31:0] rdata_q; // Read data flop
  logic [31:0] rd_mux; // Combinational read value
  logic analog_q; // Sampled analog watchdog state

  // Address decode for writes
  always_comb
  begin
    wr_cfg = bus_req.wr && (bus_req.addr == RTW_CAPTURE_SOURCE_CONFIG_ADDR);
    wr_ctrl = bus_req.wr && (bus_req.addr == RTW_WATCHDOG_CONTROL_ADDR);
    wr_prld = bus_req.wr && (bus_req.addr == RTW_WATCHDOG_PRELOAD_ADDR);
    wr_key = bus_req.wr && (bus_req.addr == RTW_WATCHDOG_KEY_ADDR);
    wr_isr = bus_req.wr && (bus_req.addr == RTW_IRQ_STATUS_ADDR);
    wr_imask = bus_req.wr && (bus_req.addr == RTW_IRQ_MASK_ADDR);
  end

  // Per-capture select, decode and latch
  generate
    for (genvar g = 0; g < RTW_NUM_CAPTURES; g++)
    begin : g_cap
      localparam int LSB = (g == 0) ? RTW_SEL0_LSB : RTW_SEL1_LSB;

      // Select field, written only through its own bit slice
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          sel_q[g] <= RTW_SEL_RESET;
        end
        else if (wr_cfg)
        begin
          sel_q[g] <= bus_req.wdata[LSB +: RTW_SEL_W];
        end
      end

      // Reserved codes trigger nothing, so a stray value stays harmless
      always_comb
      begin
        if (sel_q[g] <= RTW_SEL_MAX)
        begin
          cap_hit[g] = dma_event[sel_q[g]];
        end
        else
        begin
          cap_hit[g] = 1'b0;
        end
      end

      // Latch both counter values on the selected event
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          cap_q[g] <= '0;
          capture_pulse_q[g] <= 1'b0;
        end
        else
        begin
          capture_pulse_q[g] <= cap_hit[g];
          if (cap_hit[g])
          begin
            cap_q[g] <= counter_in[g];
          end
        end
      end
    end
  endgenerate

  // Enable is one-way: only reset turns the watchdog off again
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wd_en_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      wd_en_q <= 1'b1;
    end
  end

  // Preload register
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      preload_q <= RTW_PRELOAD_RESET;
    end
    else if (wr_prld)
    begin
      preload_q <= bus_req.wdata;
    end
  end

  // Key decode; only the low 16 bits carry the key
  always_comb
  begin
    service = wr_key && (key_q == RTW_KEY_ARMED) && (bus_req.wdata[15:0] == RTW_KEY_SECOND);
    key_bad = wr_key && !service && (bus_req.wdata[15:0] != RTW_KEY_FIRST);
    expire_now = wd_en_q && !expired_q && (cnt_q == RTW_WORD_RESET) && !service;
  end

  // Key sequence state; a first key always re-arms
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      key_q <= RTW_KEY_IDLE;
    end
    else if (wr_key)
    begin
      case (key_q)
        RTW_KEY_IDLE:
        begin
          key_q <= (bus_req.wdata[15:0] == RTW_KEY_FIRST) ? RTW_KEY_ARMED : RTW_KEY_IDLE;
        end
        RTW_KEY_ARMED:
        begin
          key_q <= (bus_req.wdata[15:0] == RTW_KEY_FIRST) ? RTW_KEY_ARMED : RTW_KEY_IDLE;
        end
        default:
        begin
          key_q <= RTW_KEY_IDLE;
        end
      endcase
    end
  end

  // Down-counter; holds at zero after expiry, no wrap
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_q <= RTW_PRELOAD_RESET;
    end
    else if (wr_ctrl && !wd_en_q)
    begin
      cnt_q <= preload_q; // Start from preload on enable
    end
    else if (service)
    begin
      cnt_q <= preload_q;
    end
    else if (wd_en_q && (cnt_q != RTW_WORD_RESET))
    begin
      cnt_q <= cnt_q - 32'h0000_0001;
    end
  end

  // Expiry and key error flags; cleared only by device reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      expired_q <= 1'b0;
      key_err_q <= 1'b0;
      wd_reset_q <= 1'b0;
      analog_q <= 1'b0;
    end
    else
    begin
      analog_q <= analog_wd_flag;
      if (expire_now)
      begin
        expired_q <= 1'b1;
        wd_reset_q <= 1'b1;
      end
      if (key_bad)
      begin
        key_err_q <= 1'b1;
      end
    end
  end

  // Interrupt events, sticky until written one; set beats clear
  always_comb
  begin
    irq_set = '0;
    irq_set[RTW_IRQ_CAPTURE0] = cap_hit[0];
    irq_set[RTW_IRQ_CAPTURE1] = cap_hit[1];
    irq_set[RTW_IRQ_EXPIRED] = expire_now;
    irq_set[RTW_IRQ_KEY_ERROR] = key_bad;
  end

  // Interrupt status, mask and output level
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      isr_q <= RTW_IRQ_RESET;
      imask_q <= RTW_IRQ_RESET;
      irq_q <= 1'b0;
    end
    else
    begin
      isr_q <= (isr_q & ~(wr_isr ? bus_req.wdata[RTW_IRQ_W-1:0] : RTW_IRQ_RESET)) | irq_set;
      if (wr_imask)
      begin
        imask_q <= bus_req.wdata[RTW_IRQ_W-1:0];
      end
      irq_q <= |(isr_q & imask_q); // One cycle behind status
    end
  end

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb
  begin
    rd_mux = RTW_WORD_RESET;
    case (bus_req.addr)
      RTW_CAPTURE_SOURCE_CONFIG_ADDR:
      begin
        rd_mux[RTW_SEL0_LSB +: RTW_SEL_W] = sel_q[0];
        rd_mux[RTW_SEL1_LSB +: RTW_SEL_W] = sel_q[1];
      end
      RTW_CAPTURE0_FRC_ADDR: rd_mux = cap_q[0].frc;
      RTW_CAPTURE0_UC_ADDR: rd_mux = cap_q[0].uc;
      RTW_CAPTURE1_FRC_ADDR: rd_mux = cap_q[1].frc;
      RTW_CAPTURE1_UC_ADDR: rd_mux = cap_q[1].uc;
      RTW_WATCHDOG_CONTROL_ADDR: rd_mux[0] = wd_en_q;
      RTW_WATCHDOG_PRELOAD_ADDR: rd_mux = preload_q;
      RTW_WATCHDOG_STATUS_ADDR:
      begin
        rd_mux[RTW_WDS_ANALOG] = analog_q;
        rd_mux[RTW_WDS_ENABLED] = wd_en_q;
        rd_mux[RTW_WDS_EXPIRED] = expired_q;
        rd_mux[RTW_WDS_KEY_ERROR] = key_err_q;
      end
      RTW_WATCHDOG_DOWN_COUNTER_ADDR: rd_mux = cnt_q;
      RTW_IRQ_STATUS_ADDR: rd_mux[RTW_IRQ_W-1:0] = isr_q;
      RTW_IRQ_MASK_ADDR: rd_mux[RTW_IRQ_W-1:0] = imask_q;
      default: rd_mux = RTW_WORD_RESET; // Key register reads zero too
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_q <= RTW_WORD_RESET;
    end
    else
    begin
      rdata_q <= bus_req.rd ? rd_mux : RTW_WORD_RESET;
    end
  end

  assign rdata = rdata_q;
  assign capture_pulse = capture_pulse_q;
  assign wd_reset_req = wd_reset_q;
  assign irq = irq_q;

  default clocking rtw_cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Checks on the capture path
  a_sel_reset_zero: assert property ($past(reset) |-> (sel_q[0] == RTW_SEL_RESET) && (sel_q[1] == RTW_SEL_RESET))
    else $error("capture select not zero after reset");
  a_sel1_field_slice: assert property (wr_cfg |=> (sel_q[1] == $past(bus_req.wdata[6:4])))
    else $error("capture 1 select not taken from bits 6:4");
  a_cap_event_latch: assert property ((dma_event[1] && sel_q[0] == 3'h1) |=> (cap_q[0] == $past(counter_in[0])))
    else $error("capture 0 did not latch counters");
  a_cap_decode_map: assert property ((sel_q[1] == 3'h4) |-> (cap_hit[1] == dma_event[4]))
    else $error("capture 1 decode wrong for code 4");
  // Checks on the watchdog
  a_wd_off_reset: assert property ($past(reset) |-> !wd_en_q && !wd_reset_q)
    else $error("watchdog active after reset");
  a_wd_enable_write: assert property (wr_ctrl |=> wd_en_q)
    else $error("control write did not enable watchdog");
  a_key_reload: assert property ((wr_key && key_q == RTW_KEY_ARMED && bus_req.wdata[15:0] == RTW_KEY_SECOND)
    |=> (cnt_q == $past(preload_q)))
    else $error("correct key pair did not reload counter");
  a_bad_key_no_reload: assert property ((wr_key && bus_req.wdata[15:0] != RTW_KEY_FIRST
    && bus_req.wdata[15:0] != RTW_KEY_SECOND
    && wd_en_q && cnt_q > 32'h0000_0001 && !wr_ctrl) |=> (cnt_q == $past(cnt_q) - 32'h0000_0001))
    else $error("wrong key reloaded counter");
  a_expire_reset: assert property ((wd_en_q && cnt_q == 32'h0000_0000 && !service && !wd_reset_q)
    |=> wd_reset_q [*2])
    else $error("expiry did not raise reset request");
  a_cntr_readback: assert property ((bus_req.rd && bus_req.addr == RTW_WATCHDOG_DOWN_COUNTER_ADDR)
    |=> (rdata == $past(cnt_q)))
    else $error("down-counter read mismatch");
  a_status_readback: assert property ((bus_req.rd && bus_req.addr == RTW_WATCHDOG_STATUS_ADDR)
    |=> (rdata[RTW_WDS_EXPIRED] == $past(expired_q)) && (rdata[RTW_WDS_ENABLED] == $past(wd_en_q)))
    else $error("watchdog status read mismatch");
  a_preload_write: assert property (wr_prld |=> (preload_q == $past(bus_req.wdata)))
    else $error("preload not stored");

  // Main scenarios
  c_capture_hit: cover property (cap_hit[0] ##1 capture_pulse[0]);
  c_service_seq: cover property (service ##1 (cnt_q == $past(preload_q)));
  c_expiry: cover property (expire_now ##1 wd_reset_req);
  c_irq_raise: cover property (!irq ##1 irq);

endmodule

/* rtl/rtw_pkg.sv */
// Package for the capture source select and digital watchdog register block
package rtw_pkg;
  // Byte addresses of the registers
  localparam logic [31:0] RTW_CAPTURE_SOURCE_CONFIG_ADDR = 32'h4000_0014;
  localparam logic [31:0] RTW_CAPTURE0_FRC_ADDR = 32'h4200_0020;
  localparam logic [31:0] RTW_CAPTURE0_UC_ADDR = 32'h4200_0024;
  localparam logic [31:0] RTW_CAPTURE1_FRC_ADDR = 32'h4200_0040;
  localparam logic [31:0] RTW_CAPTURE1_UC_ADDR = 32'h4200_0044;
  localparam logic [31:0] RTW_WATCHDOG_CONTROL_ADDR = 32'h4200_0090;
  localparam logic [31:0] RTW_WATCHDOG_PRELOAD_ADDR = 32'h4200_0094;
  localparam logic [31:0] RTW_WATCHDOG_STATUS_ADDR = 32'h4200_0098;
  localparam logic [31:0] RTW_WATCHDOG_KEY_ADDR = 32'h4200_009C;
  localparam logic [31:0] RTW_WATCHDOG_DOWN_COUNTER_ADDR = 32'h4200_00A0;
  localparam logic [31:0] RTW_IRQ_STATUS_ADDR = 32'h4200_00B0;
  localparam logic [31:0] RTW_IRQ_MASK_ADDR = 32'h4200_00B4;

  // Capture select field positions and width
  localparam int RTW_SEL_W = 3;
  localparam int RTW_SEL0_LSB = 0;
  localparam int RTW_SEL1_LSB = 4;
  localparam logic [2:0] RTW_SEL_RESET = 3'h0;
  localparam logic [2:0] RTW_SEL_MAX = 3'h5;
  localparam int RTW_NUM_EVENTS = 6;
  localparam int RTW_NUM_CAPTURES = 2;

  // Key values for servicing
  localparam logic [15:0] RTW_KEY_FIRST = 16'hE51A;
  localparam logic [15:0] RTW_KEY_SECOND = 16'hA35C;

  // Watchdog status bit positions
  localparam int RTW_WDS_ANALOG = 0;
  localparam int RTW_WDS_ENABLED = 1;
  localparam int RTW_WDS_EXPIRED = 2;
  localparam int RTW_WDS_KEY_ERROR = 3;

  // Interrupt status bit positions
  localparam int RTW_IRQ_W = 4;
  localparam int RTW_IRQ_CAPTURE0 = 0;
  localparam int RTW_IRQ_CAPTURE1 = 1;
  localparam int RTW_IRQ_EXPIRED = 2;
  localparam int RTW_IRQ_KEY_ERROR = 3;

  // Reset values
  localparam logic [31:0] RTW_PRELOAD_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] RTW_WORD_RESET = 32'h0000_0000;
  localparam logic [RTW_IRQ_W-1:0] RTW_IRQ_RESET = 4'h0;

  // Key sequence states
  typedef enum logic [0:0] {
    RTW_KEY_IDLE,
    RTW_KEY_ARMED
  } rtw_key_state_e;

  // Counter values seen by one capture unit
  typedef struct packed {
    logic [31:0] frc;
    logic [31:0] uc;
  } rtw_count_s;

  // Register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rtw_bus_req_s;
endpackage

/* verification/rtw_event_src.sv */
// Model of the serial port DMA event sources and the live timer counters
`timescale 1ns/1ps
module rtw_event_src
  import rtw_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [RTW_NUM_EVENTS-1:0] ev_req, // Event request from bench
  output logic [RTW_NUM_EVENTS-1:0] dma_event, // One-cycle DMA event pulses
  output rtw_count_s [RTW_NUM_CAPTURES-1:0] counter_in // Live counter values
);
  logic [31:0] tick_q; // Free-running base count

  // Base count runs every cycle so each capture sees a fresh value
  always_ff @(posedge clk)
  begin
    if (reset)
      tick_q <= 32'h0;
    else
      tick_q <= tick_q + 32'h1;
  end

  // Events launched just after the edge and held for one cycle only
  always_ff @(posedge clk)
  begin
    dma_event <= reset ? '0 : ev_req;
  end

  // Distinct values per capture, so a swapped latch cannot pass
  assign counter_in[0] = '{frc: tick_q, uc: ~tick_q};
  assign counter_in[1] = '{frc: tick_q + 32'h1000, uc: tick_q ^ 32'hA5A5_0000};
endmodule

/* verification/tb.sv */
// Self-checking bench for the capture select and watchdog register block
`timescale 1ns/1ps
module tb
  import rtw_pkg::*;
;
  logic clk; // System clock
  logic reset; // Synchronous reset
  rtw_bus_req_s bus_req; // Register port request
  logic [31:0] rdata; // Read data
  logic [RTW_NUM_EVENTS-1:0] ev_req; // Event requests to the model
  logic [RTW_NUM_EVENTS-1:0] dma_event; // Events from the model
  rtw_count_s [RTW_NUM_CAPTURES-1:0] counter_in; // Counters from the model
  logic analog_wd_flag; // Analog watchdog level
  logic [1:0] capture_pulse; // Capture pulses
  logic wd_reset_req; // Reset request
  logic irq; // Interrupt
  int failures; // Mismatch count
  int samples_checked; // Comparison count
  int cycles; // Cycle count for the hang limit

  rtw_event_src src (.clk(clk), .reset(reset), .ev_req(ev_req), .dma_event(dma_event), .counter_in(counter_in));
  rtw_capture_watchdog uut (.clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata), .dma_event(dma_event),
    .counter_in(counter_in), .analog_wd_flag(analog_wd_flag), .capture_pulse(capture_pulse),
    .wd_reset_req(wd_reset_req), .irq(irq));

  // Clock at 25 MHz
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang limit, well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end

  // Word comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  // One-cycle read strobe; data taken in the following cycle only
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Read and compare
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    rd(a, v);
    check(v, exp, what);
  endtask

  // Raise events, then check the pulses and the latched counter pair
  task automatic fire(input logic [5:0] m, input logic [1:0] ep, input int g);
    logic [31:0] f, u;
    @(posedge clk);
    ev_req <= m;
    @(posedge clk);
    ev_req <= '0;
    #1 f = counter_in[g].frc;
    u = counter_in[g].uc;
    @(posedge clk);
    #1 check({30'h0, capture_pulse}, {30'h0, ep}, "capture pulse");
    if (ep != 2'h0)
    begin
      rd_chk(g ? RTW_CAPTURE1_FRC_ADDR : RTW_CAPTURE0_FRC_ADDR, f, "capture frc");
      rd_chk(g ? RTW_CAPTURE1_UC_ADDR : RTW_CAPTURE0_UC_ADDR, u, "capture uc");
    end
  endtask

  // Two key writes, then the counter read back
  task automatic svc(input logic [15:0] k1, input logic [15:0] k2, output logic [31:0] v);
    wr(RTW_WATCHDOG_KEY_ADDR, {16'h0, k1});
    wr(RTW_WATCHDOG_KEY_ADDR, {16'h0, k2});
    rd(RTW_WATCHDOG_DOWN_COUNTER_ADDR, v);
  endtask

  // Values after reset, unmapped and write-only places
  task automatic t_reset();
    rd_chk(RTW_CAPTURE_SOURCE_CONFIG_ADDR, 32'h0, "config reset");
    rd_chk(RTW_WATCHDOG_CONTROL_ADDR, 32'h0, "control reset");
    rd_chk(RTW_WATCHDOG_PRELOAD_ADDR, 32'hFFFF_FFFF, "preload reset");
    rd_chk(RTW_WATCHDOG_STATUS_ADDR, 32'h1, "status reset");
    // Drop the analog level so a status bit stuck high cannot pass
    @(posedge clk);
    analog_wd_flag <= 1'b0;
    rd_chk(RTW_WATCHDOG_STATUS_ADDR, 32'h0, "analog low");
    @(posedge clk);
    analog_wd_flag <= 1'b1;
    rd_chk(RTW_WATCHDOG_DOWN_COUNTER_ADDR, 32'hFFFF_FFFF, "idle counter");
    rd_chk(RTW_WATCHDOG_DOWN_COUNTER_ADDR, 32'hFFFF_FFFF, "idle counter");
    rd_chk(RTW_WATCHDOG_KEY_ADDR, 32'h0, "key read");
    rd_chk(32'h4200_0070, 32'h0, "unmapped read");
    $display("test reset done");
  endtask

  // Select codes 0 to 5 on both captures, then events that no field selects
  task automatic t_capture();
    for (int i = 0; i < 6; i++)
    begin
      wr(RTW_CAPTURE_SOURCE_CONFIG_ADDR, {25'h0, 3'(5 - i), 1'b0, 3'(i)});
      rd_chk(RTW_CAPTURE_SOURCE_CONFIG_ADDR, {25'h0, 3'(5 - i), 1'b0, 3'(i)}, "config");
      fire(6'h01 << i, 2'h1, 0);
      fire(6'h01 << (5 - i), 2'h2, 1);
    end
    wr(RTW_CAPTURE_SOURCE_CONFIG_ADDR, 32'h0000_0000);
    fire(6'h3E, 2'h0, 0);
    $display("test capture done");
  endtask

  // Sticky status, mask and write-one-to-clear
  task automatic t_irq();
    rd_chk(RTW_IRQ_STATUS_ADDR, 32'h3, "irq status");
    check({31'h0, irq}, 32'h0, "irq masked");
    wr(RTW_IRQ_MASK_ADDR, 32'h1);
    rd_chk(RTW_IRQ_MASK_ADDR, 32'h1, "irq mask");
    check({31'h0, irq}, 32'h1, "irq raised");
    wr(RTW_IRQ_STATUS_ADDR, 32'h1);
    rd_chk(RTW_IRQ_STATUS_ADDR, 32'h2, "irq cleared");
    check({31'h0, irq}, 32'h0, "irq dropped");
    $display("test irq done");
  endtask

  // Enable, count, service, bad key and expiry
  task automatic t_watchdog();
    logic [31:0] a, b, v, v2;
    wr(RTW_WATCHDOG_PRELOAD_ADDR, 32'h0000_00C8);
    rd_chk(RTW_WATCHDOG_PRELOAD_ADDR, 32'h0000_00C8, "preload");
    wr(RTW_WATCHDOG_CONTROL_ADDR, 32'h1);
    rd_chk(RTW_WATCHDOG_CONTROL_ADDR, 32'h1, "control");
    rd_chk(RTW_WATCHDOG_STATUS_ADDR, 32'h3, "status on");
    rd(RTW_WATCHDOG_DOWN_COUNTER_ADDR, a);
    wr(RTW_WATCHDOG_DOWN_COUNTER_ADDR, 32'h0);
    rd(RTW_WATCHDOG_DOWN_COUNTER_ADDR, b);
    check(b, a - 32'h0000_0004, "counter runs");
    wr(RTW_WATCHDOG_STATUS_ADDR, 32'hFFFF_FFFF);
    rd_chk(RTW_WATCHDOG_STATUS_ADDR, 32'h3, "status read only");
    svc(RTW_KEY_FIRST, RTW_KEY_SECOND, v);
    check(v, 32'h0000_00C7, "reload");
    svc(RTW_KEY_FIRST, RTW_KEY_SECOND, v2);
    check(v2, v, "second reload");
    svc(RTW_KEY_FIRST, 16'h1234, v2);
    check({31'h0, v2 < v}, 32'h1, "bad key no reload");
    rd_chk(RTW_WATCHDOG_STATUS_ADDR, 32'hB, "key error");
    wr(RTW_WATCHDOG_PRELOAD_ADDR, 32'h0000_0014);
    svc(RTW_KEY_FIRST, RTW_KEY_SECOND, v);
    repeat (12) @(posedge clk);
    #1 check({31'h0, wd_reset_req}, 32'h0, "no early reset");
    repeat (15) @(posedge clk);
    #1 check({31'h0, wd_reset_req}, 32'h1, "expiry reset");
    rd_chk(RTW_WATCHDOG_STATUS_ADDR, 32'hF, "expired");
    rd_chk(RTW_IRQ_STATUS_ADDR, 32'hE, "irq events");
    $display("test watchdog done");
  endtask

  // Reset again after expiry; the watchdog must come back off
  task automatic t_rereset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1 check({31'h0, wd_reset_req}, 32'h0, "reset request cleared");
    rd_chk(RTW_WATCHDOG_CONTROL_ADDR, 32'h0, "control after reset");
    rd_chk(RTW_WATCHDOG_STATUS_ADDR, 32'h1, "status after reset");
    rd_chk(RTW_WATCHDOG_DOWN_COUNTER_ADDR, 32'hFFFF_FFFF, "counter after reset");
    rd_chk(RTW_CAPTURE_SOURCE_CONFIG_ADDR, 32'h0, "config after reset");
    $display("test second reset done");
  endtask

  // Main sequence
  initial
  begin
    reset = 1'b1;
    bus_req = '0;
    ev_req = '0;
    analog_wd_flag = 1'b1;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_capture();
    t_irq();
    t_watchdog();
    t_rereset();
    conclude();
  end
endmodule
